/* sim/testbench.sv */
// self-checking bench for the waveform capture buffer
`include "wcb_defines.vh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam [13:0] A_CFG = {`WCB_IDX_CONFIG, 2'b00};
	localparam [13:0] A_MSK = {`WCB_IDX_PAGE_MASK, 2'b00};
	localparam [13:0] A_ST = {`WCB_IDX_STATUS_WORD_ZERO, 2'b00};
	localparam [13:0] A_TS = {`WCB_IDX_TRIG_STATE, 2'b00};
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic run = 1'b0;
	logic [13:0] s_axi_awaddr = 14'h0000;
	logic [13:0] s_axi_araddr = 14'h0000;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire interrupt_line_zero, raw_strobe, lpf_strobe, pcf_strobe;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [167:0] raw_data, lpf_data;
	wire [223:0] pcf_data;
	int n_errors = 0;
	int cmp_count = 0;
	logic [31:0] d;
	wcb_top u_wcb_top (
		.clk_sys(clk_sys),
		.rst(rst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.raw_strobe(raw_strobe), .raw_data(raw_data),
		.lpf_strobe(lpf_strobe), .lpf_data(lpf_data),
		.pcf_strobe(pcf_strobe), .pcf_data(pcf_data),
		.interrupt_line_zero(interrupt_line_zero)
	);
	wcb_src_model u_wcb_src_model (
		.clk_sys(clk_sys),
		.rst(rst),
		.run(run),
		.raw_strobe(raw_strobe), .raw_data(raw_data),
		.lpf_strobe(lpf_strobe), .lpf_data(lpf_data),
		.pcf_strobe(pcf_strobe), .pcf_data(pcf_data)
	);
	initial forever #12.5 clk_sys = ~clk_sys;
	// ----
	// helpers
	// ----
	function automatic [31:0] ew(input [2:0] g, input [8:0] k, input [2:0] c);
		logic [23:0] s;
		s = {~k[0], c, g, k, 8'h3C};
		ew = (g == 3'h3) ? {s, 8'h5A} : {{4{s[23]}}, s, 4'h0};
	endfunction
	function automatic [13:0] ma(input int s, input int c);
		ma = 14'h2000 + 14'(s * 32 + c * 4);
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input [13:0] a, input [31:0] v, input [1:0] er);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// no cycle count is assumed: only the watchdog ends a stuck wait
		do begin
			@(posedge clk_sys);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk({30'h0, s_axi_bresp}, {30'h0, er});
	endtask
	task automatic rd(input [13:0] a, input [1:0] er);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		s_axi_rready <= 1'b0;
		chk({30'h0, s_axi_rresp}, {30'h0, er});
	endtask
	task automatic wirq;
		for (int i = 0; i < 6000 && interrupt_line_zero !== 1'b1; i++) @(posedge clk_sys);
		chk({31'h0, interrupt_line_zero}, 32'h1);
	endtask
	task automatic poll;
		// a full wrap at the slow rate needs a little over 4000 polls
		for (int i = 0; i < 6000; i++) begin
			rd(A_ST, `WCB_RESP_OKAY);
			if (d[0] === 1'b1) break;
		end
		chk(d & 32'h1, 32'h1);
	endtask
	// restart capture: source stops, enable drops, flag cleared, new setup
	task automatic cap(input [31:0] cfg);
		run <= 1'b0;
		wr(A_CFG, `WCB_CFG_RESET, `WCB_RESP_OKAY);
		wr(A_ST, 32'h1, `WCB_RESP_OKAY);
		wr(A_CFG, cfg, `WCB_RESP_OKAY);
		run <= 1'b1;
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ----
	// watchdog and main sequence
	// ----
	initial begin
		repeat (80000) @(posedge clk_sys);
		n_errors++;
		finish_test;
	end
	initial begin
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		rd(A_CFG, `WCB_RESP_OKAY);
		chk(d, `WCB_CFG_RESET);
		rd(A_MSK, `WCB_RESP_OKAY);
		chk(d, `WCB_MASK_RESET);
		rd(14'h0410, `WCB_RESP_SLVERR);
		chk(d, 32'h0);
		wr(14'h0410, 32'h1, `WCB_RESP_SLVERR);
		wr(A_MSK, 32'h8001, `WCB_RESP_OKAY);
		cap(32'h31);
		wirq;
		rd(A_TS, `WCB_RESP_OKAY);
		chk(d, 32'h0);
		wr(A_ST, 32'h1, `WCB_RESP_OKAY);
		// the line is registered behind the flag, so it drops one edge later
		@(posedge clk_sys);
		chk({31'h0, interrupt_line_zero}, 32'h0);
		wirq;
		rd(A_TS, `WCB_RESP_OKAY);
		chk(d, 32'hF);
		repeat (400) @(posedge clk_sys);
		for (int c = 0; c < 7; c++) begin
			rd(ma(0, c), `WCB_RESP_OKAY);
			chk(d, ew(3'h1, 9'h000, 3'(c)));
		end
		rd(ma(255, 6), `WCB_RESP_OKAY);
		chk(d, ew(3'h1, 9'hFF, 3'h6));
		cap(32'h215);
		poll;
		chk({31'h0, interrupt_line_zero}, 32'h0);
		rd(A_TS, `WCB_RESP_OKAY);
		chk(d, 32'h0);
		rd(ma(0, 0), `WCB_RESP_OKAY);
		chk(d, ew(3'h2, 9'h000, 3'h0));
		cap(32'h303);
		poll;
		rd(ma(0, 5), `WCB_RESP_OKAY);
		chk(d, ew(3'h3, 9'h000, 3'h5));
		rd(ma(0, 6), `WCB_RESP_OKAY);
		chk(d, ew(3'h2, 9'h000, 3'h6));
		// page 0 alone, so the poll waits for the wrap and not for page 15
		wr(A_MSK, 32'h1, `WCB_RESP_OKAY);
		wr(A_ST, 32'h1, `WCB_RESP_OKAY);
		poll;
		rd(ma(0, 0), `WCB_RESP_OKAY);
		chk(d, ew(3'h3, 9'h100, 3'h0));
		rd(ma(1, 1), `WCB_RESP_OKAY);
		chk(d, ew(3'h3, 9'h101, 3'h1));
		finish_test;
	end
endmodule

/* sim/wcb_src_model.sv */
// signal chain model: raw, filtered and processed sample sets
module wcb_src_model (
	input wire clk_sys,
	input wire rst,
	input wire run,
	output reg raw_strobe = 1'b0,
	output reg [167:0] raw_data,
	output reg lpf_strobe = 1'b0,
	output reg [167:0] lpf_data,
	output reg pcf_strobe = 1'b0,
	output reg [223:0] pcf_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] t = 6'h00;
	logic [8:0] kr = 9'h000;
	logic [8:0] kl = 9'h000;
	logic [8:0] kp = 9'h000;
	function automatic [23:0] smp(input [2:0] g, input [8:0] k, input [2:0] c);
		smp = {~k[0], c, g, k, 8'h3C};
	endfunction
	// all seven channels of one instant, coded with set number and source
	always @* begin
		for (int c = 0; c < 7; c++) begin
			raw_data[c*24+:24] = smp(3'h1, kr, 3'(c));
			lpf_data[c*24+:24] = smp(3'h2, kl, 3'(c));
			pcf_data[c*32+:32] = {smp(3'h3, kp, 3'(c)), 8'h5A};
		end
	end
	// raw sets come four times as often as the others
	always @(posedge clk_sys) begin
		if (rst || !run) begin
			t <= 6'h00;
			kr <= 9'h000;
			kl <= 9'h000;
			kp <= 9'h000;
			raw_strobe <= 1'b0;
			lpf_strobe <= 1'b0;
			pcf_strobe <= 1'b0;
		end else begin
			t <= t + 6'h01;
			raw_strobe <= (t[3:0] == 4'hF);
			lpf_strobe <= (t == 6'h3F);
			pcf_strobe <= (t == 6'h3F);
			kr <= kr + {8'h00, raw_strobe};
			kl <= kl + {8'h00, lpf_strobe};
			kp <= kp + {8'h00, pcf_strobe};
		end
	end
endmodule

/* sim/wcb_sva.sv */
// checker for the capture buffer bus and interrupt ports
module wcb_sva #(
	parameter ADDR_W = 14
) (
	input wire clk_sys,
	input wire rst,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire raw_strobe,
	input wire lpf_strobe,
	input wire pcf_strobe,
	input wire interrupt_line_zero
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	wire [11:0] ar_idx = s_axi_araddr[ADDR_W-1:2];
	wire ar_take = s_axi_arvalid && s_axi_arready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	reg ar_bad;
	reg [7:0] since_smp;
	// ----
	// helpers
	// ----
	always @(posedge clk_sys) begin
		if (rst) begin
			ar_bad <= 1'b0;
			since_smp <= 8'hFF;
		end else begin
			if (ar_take)
				ar_bad <= !(ar_idx[11] || ar_idx[11:2] == 10'h040);
			if (raw_strobe || lpf_strobe || pcf_strobe)
				since_smp <= 8'h00;
			else if (since_smp != 8'hFF)
				since_smp <= since_smp + 8'h01;
		end
	end
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && w_take;
	endsequence
	sequence s_rd_take;
		ar_take;
	endsequence
	a_b_latency: assert property (s_wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response not two edges after take");
	a_wr_refuse: assert property (s_wr_take |=> !s_axi_awready && !s_axi_wready)
		else $error("write taken again before response");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_rd_reg: assert property (ar_take && !ar_idx[11] |=> !s_axi_rvalid ##1 s_axi_rvalid)
		else $error("register read latency wrong");
	a_rd_mem: assert property (ar_take && ar_idx[11] |=> !s_axi_rvalid [*2] ##1 s_axi_rvalid)
		else $error("memory read latency wrong");
	a_ar_refuse: assert property (s_rd_take |=> !s_axi_arready)
		else $error("read taken again before answer");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed while waiting");
	a_rd_unmapped: assert property (s_axi_rvalid && ar_bad |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	a_irq_cause: assert property ($rose(interrupt_line_zero) |-> since_smp <= 8'h20)
		else $error("interrupt rose without a stored set");
	a_irq_clear: assert property ($fell(interrupt_line_zero) |-> $past(w_take, 2) || $past(w_take, 3))
		else $error("interrupt fell without a write");
endmodule

bind wcb_top wcb_sva #(.ADDR_W(ADDR_W)) u_wcb_sva (
	.clk_sys(clk_sys),
	.rst(rst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.raw_strobe(raw_strobe), .lpf_strobe(lpf_strobe), .pcf_strobe(pcf_strobe),
	.interrupt_line_zero(interrupt_line_zero)
);

/* src/wcb_defines.vh */
// constants for the waveform capture buffer
`ifndef WCB_DEFINES_VH
`define WCB_DEFINES_VH

// ----------------------------------------------------------------
// register word indices (byte address is four times the index)
// ----------------------------------------------------------------
`define WCB_IDX_MEM_FIRST 12'h800
`define WCB_IDX_MEM_LAST 12'hFFF
`define WCB_IDX_CONFIG 12'h100
`define WCB_IDX_PAGE_MASK 12'h101
`define WCB_IDX_STATUS_WORD_ZERO 12'h102
`define WCB_IDX_TRIG_STATE 12'h103

// ----------------------------------------------------------------
// capture_config_reg fields
// ----------------------------------------------------------------
`define WCB_CFG_CAP_EN 0
`define WCB_CFG_MODE_LO 1
`define WCB_CFG_MODE_HI 2
`define WCB_CFG_KIND_SEL 3
`define WCB_CFG_NEUTRAL_EN 4
`define WCB_CFG_IRQ_EN 5
`define WCB_CFG_SRC_LO 8
`define WCB_CFG_SRC_HI 9
`define WCB_CFG_RESET 32'h00000010
`define WCB_CFG_MASK 32'h0000033F

// ----------------------------------------------------------------
// status and trigger state fields
// ----------------------------------------------------------------
`define WCB_ST_PAGE_FULL 0
`define WCB_TS_PAGE_LO 0
`define WCB_TS_PAGE_HI 3
`define WCB_MASK_RESET 32'h00000000

// ----------------------------------------------------------------
// codes
// ----------------------------------------------------------------
`define WCB_SRC_RAW 2'h0
`define WCB_SRC_LPF 2'h2
`define WCB_SRC_PCF 2'h3
`define WCB_MODE_STOP_FULL 2'h0
`define WCB_SLOT_NEUTRAL 3'h6
`define WCB_SLOT_SPARE 3'h7
`define WCB_PAGE_LAST_WORD 7'h7F
`define WCB_BUF_LAST_WORD 11'h7FF
`define WCB_RESP_OKAY 2'h0
`define WCB_RESP_SLVERR 2'h2

`endif

/* src/wcb_fifo.v */
// small synchronous fifo with valid and ready on both sides
module wcb_fifo #(
	parameter WIDTH = 33,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire clk_sys,
	input wire rst,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] store [0:DEPTH-1];
	reg [AW-1:0] rd_ptr;
	reg [AW-1:0] wr_ptr;
	reg [AW:0] count;
	wire push;
	wire pop;

	assign in_ready = (count != DEPTH[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data = store[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always @(posedge clk_sys) begin
		if (push) begin
			store[wr_ptr] <= in_data;
		end
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			rd_ptr <= {AW{1'b0}};
			wr_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule

/* src/wcb_mem.v */
// single-port capture memory with registered read data
module wcb_mem #(
	parameter WORDS = 2048,
	parameter AW = 11
) (
	input wire clk_sys,
	input wire [AW-1:0] addr,
	input wire we,
	input wire [31:0] wdata,
	output reg [31:0] rdata
);
	reg [31:0] cells [0:WORDS-1];

	always @(posedge clk_sys) begin
		if (we) begin
			cells[addr] <= wdata;
		end
		rdata <= cells[addr];
	end
endmodule

/* src/wcb_top.v */
// waveform capture buffer: sample formatting, paging and AXI4-Lite access
//
// Added by the designer: the AXI4-Lite slave port and the address map.
`include "wcb_defines.vh"
module wcb_top #(
	parameter ADDR_W = 14,
	parameter FIFO_DEPTH = 8,
	parameter MEM_WORDS = 2048
) (
	input wire clk_sys,
	input wire rst,
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire raw_strobe,
	input wire [167:0] raw_data,
	input wire lpf_strobe,
	input wire [167:0] lpf_data,
	input wire pcf_strobe,
	input wire [223:0] pcf_data,
	output reg interrupt_line_zero
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function [31:0] fmt24;
		input [23:0] s;
		begin
			fmt24 = {{4{s[23]}}, s, 4'h0};
		end
	endfunction

	function [31:0] merge_bytes;
		input [31:0] old_v;
		input [31:0] new_v;
		input [3:0] strb;
		integer b;
		begin
			merge_bytes = old_v;
			for (b = 0; b < 4; b = b + 1) begin
				if (strb[b]) begin
					merge_bytes[b*8 +: 8] = new_v[b*8 +: 8];
				end
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	reg [31:0] capture_config_reg;
	reg [15:0] page_notify_mask;
	reg page_full;
	reg [3:0] last_filled_page;
	reg cap_en_d;
	reg stopped;
	reg [10:0] wr_ptr;

	wire capture_enable = capture_config_reg[`WCB_CFG_CAP_EN];
	wire [1:0] fill_mode = capture_config_reg[`WCB_CFG_MODE_HI:`WCB_CFG_MODE_LO];
	wire neutral_channel_enable = capture_config_reg[`WCB_CFG_NEUTRAL_EN];
	wire page_irq_en = capture_config_reg[`WCB_CFG_IRQ_EN];
	wire [1:0] capture_source_field = capture_config_reg[`WCB_CFG_SRC_HI:`WCB_CFG_SRC_LO];
	wire cap_rise = capture_enable && !cap_en_d;

	// ----------------------------------------------------------------
	// sample set formatter
	// ----------------------------------------------------------------
	localparam F_IDLE = 2'b01;
	localparam F_SEND = 2'b10;
	reg [1:0] f_state;
	reg [2:0] slot;
	reg [223:0] set_words;
	reg sel_strobe;
	reg [223:0] sel_words;
	integer c;
	wire f_ready;
	wire f_valid = f_state[1];
	wire slot_we = (slot != `WCB_SLOT_SPARE) &&
		!(slot == `WCB_SLOT_NEUTRAL && !neutral_channel_enable);
	wire [31:0] slot_word = (slot == `WCB_SLOT_SPARE) ? 32'h00000000 : set_words[slot*32 +: 32];

	// the three sources run at fixed rates of their own; strobes pace the sets
	always @* begin
		sel_strobe = 1'b0;
		sel_words = {224{1'b0}};
		case (capture_source_field)
			`WCB_SRC_RAW: begin
				sel_strobe = raw_strobe;
				for (c = 0; c < 7; c = c + 1) begin
					sel_words[c*32 +: 32] = fmt24(raw_data[c*24 +: 24]);
				end
			end
			`WCB_SRC_LPF: begin
				sel_strobe = lpf_strobe;
				for (c = 0; c < 7; c = c + 1) begin
					sel_words[c*32 +: 32] = fmt24(lpf_data[c*24 +: 24]);
				end
			end
			`WCB_SRC_PCF: begin
				sel_strobe = pcf_strobe;
				sel_words = pcf_data;
			end
			default: begin
				sel_strobe = 1'b0;
			end
		endcase
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			f_state <= F_IDLE;
			slot <= 3'h0;
			set_words <= {224{1'b0}};
		end else begin
			case (f_state)
				F_IDLE: begin
					// a strobe while busy is dropped: a set must land whole
					if (sel_strobe && capture_enable && !stopped && !cap_rise) begin
						set_words <= sel_words;
						slot <= 3'h0;
						f_state <= F_SEND;
					end
				end
				F_SEND: begin
					if (!capture_enable) begin
						f_state <= F_IDLE;
					end else if (f_ready) begin
						slot <= slot + 3'h1;
						if (slot == `WCB_SLOT_SPARE) begin
							f_state <= F_IDLE;
						end
					end
				end
				default: begin
					f_state <= F_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// fifo and memory
	// ----------------------------------------------------------------
	wire q_valid;
	wire q_ready;
	wire [32:0] q_data;
	reg rd_mem_cycle;
	reg [10:0] rd_mem_addr;
	wire [31:0] mem_rdata;
	wire pop = q_valid && q_ready;
	wire writing = pop && capture_enable && !stopped && !cap_rise;

	// host memory reads take the single port, so the drain stalls behind them
	assign q_ready = !rd_mem_cycle;

	wcb_fifo #(.WIDTH(33), .DEPTH(FIFO_DEPTH), .AW(3)) u_fifo (
		.clk_sys(clk_sys),
		.rst(rst),
		.in_valid(f_valid && capture_enable),
		.in_ready(f_ready),
		.in_data({slot_we, slot_word}),
		.out_valid(q_valid),
		.out_ready(q_ready),
		.out_data(q_data)
	);

	wcb_mem #(.WORDS(MEM_WORDS), .AW(11)) u_mem (
		.clk_sys(clk_sys),
		.addr(rd_mem_cycle ? rd_mem_addr : wr_ptr),
		.we(writing && q_data[32]),
		.wdata(q_data[31:0]),
		.rdata(mem_rdata)
	);

	// ----------------------------------------------------------------
	// fill pointer and page tracking
	// ----------------------------------------------------------------
	reg set_page_full;

	always @* begin
		set_page_full = writing && (wr_ptr[6:0] == `WCB_PAGE_LAST_WORD) &&
			page_notify_mask[wr_ptr[10:7]];
	end

	always @(posedge clk_sys) begin
		if (rst) begin
			cap_en_d <= 1'b0;
			wr_ptr <= 11'h000;
			stopped <= 1'b0;
			last_filled_page <= 4'h0;
		end else begin
			cap_en_d <= capture_enable;
			if (cap_rise) begin
				wr_ptr <= 11'h000;
				stopped <= 1'b0;
			end else if (writing) begin
				wr_ptr <= wr_ptr + 11'h001;
				if (wr_ptr[6:0] == `WCB_PAGE_LAST_WORD) begin
					last_filled_page <= wr_ptr[10:7];
				end
				if (wr_ptr == `WCB_BUF_LAST_WORD && fill_mode == `WCB_MODE_STOP_FULL) begin
					stopped <= 1'b1;
				end
			end
			if (!capture_enable) begin
				last_filled_page <= 4'h0;
			end
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite write side
	// ----------------------------------------------------------------
	reg aw_got;
	reg w_got;
	reg [11:0] aw_idx;
	reg [31:0] w_data;
	reg [3:0] w_strb;
	wire do_write = aw_got && w_got && !s_axi_bvalid;
	wire wr_cfg = do_write && aw_idx == `WCB_IDX_CONFIG;
	wire wr_mask = do_write && aw_idx == `WCB_IDX_PAGE_MASK;
	wire wr_stat = do_write && aw_idx == `WCB_IDX_STATUS_WORD_ZERO;
	wire wr_ok = wr_cfg || wr_mask || wr_stat || aw_idx[11];
	wire [31:0] mask_merged = merge_bytes({16'h0000, page_notify_mask}, w_data, w_strb);

	always @(posedge clk_sys) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `WCB_RESP_OKAY;
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_idx <= 12'h000;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			capture_config_reg <= `WCB_CFG_RESET;
			page_notify_mask <= 16'h0000;
			page_full <= 1'b0;
			interrupt_line_zero <= 1'b0;
		end else begin
			if (s_axi_awready && s_axi_awvalid) begin
				aw_got <= 1'b1;
				aw_idx <= s_axi_awaddr[13:2];
				s_axi_awready <= 1'b0;
			end else if (!aw_got && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wready && s_axi_wvalid) begin
				w_got <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end else if (!w_got && !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
			end
			// memory words are read-only to the host; such writes are ignored
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `WCB_RESP_OKAY : `WCB_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_got <= 1'b0;
				w_got <= 1'b0;
			end
			if (wr_cfg) begin
				capture_config_reg <= merge_bytes(capture_config_reg, w_data, w_strb) &
					`WCB_CFG_MASK;
			end
			if (wr_mask) begin
				page_notify_mask <= mask_merged[15:0];
			end
			// write one to clear; a fill in the same cycle keeps the flag
			if (set_page_full) begin
				page_full <= 1'b1;
			end else if (wr_stat && w_strb[0] && w_data[`WCB_ST_PAGE_FULL]) begin
				page_full <= 1'b0;
			end
			interrupt_line_zero <= (page_full || set_page_full) && page_irq_en;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read side
	// ----------------------------------------------------------------
	reg [11:0] ar_idx;
	reg rd_wait;
	reg rd_from_mem;

	always @(posedge clk_sys) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `WCB_RESP_OKAY;
			ar_idx <= 12'h000;
			rd_mem_cycle <= 1'b0;
			rd_mem_addr <= 11'h000;
			rd_wait <= 1'b0;
			rd_from_mem <= 1'b0;
		end else begin
			rd_mem_cycle <= 1'b0;
			if (s_axi_arready && s_axi_arvalid) begin
				s_axi_arready <= 1'b0;
				ar_idx <= s_axi_araddr[13:2];
				rd_mem_addr <= s_axi_araddr[12:2];
				rd_mem_cycle <= s_axi_araddr[13];
				rd_from_mem <= s_axi_araddr[13];
				rd_wait <= 1'b1;
			end else if (!rd_wait && !s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
			// wait one extra cycle so memory data has left its register
			if (rd_wait && !rd_mem_cycle) begin
				rd_wait <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `WCB_RESP_OKAY;
				if (rd_from_mem) begin
					s_axi_rdata <= mem_rdata;
				end else if (ar_idx == `WCB_IDX_CONFIG) begin
					s_axi_rdata <= capture_config_reg;
				end else if (ar_idx == `WCB_IDX_PAGE_MASK) begin
					s_axi_rdata <= {16'h0000, page_notify_mask};
				end else if (ar_idx == `WCB_IDX_STATUS_WORD_ZERO) begin
					s_axi_rdata <= {31'h00000000, page_full};
				end else if (ar_idx == `WCB_IDX_TRIG_STATE) begin
					s_axi_rdata <= {28'h0000000, last_filled_page};
				end else begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `WCB_RESP_SLVERR;
				end
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule
